// ==== src/gdf_cfg.svh ====
`ifndef GDF_CFG_SVH
`define GDF_CFG_SVH

// system clock period
`define GDF_CLK_NS 8

// both pwm inputs low for this long clear the fault memory
`define GDF_REACT_MS 60
`define GDF_REACT_CYC ((`GDF_REACT_MS * 1000000 + `GDF_CLK_NS - 1) / `GDF_CLK_NS)

// half-bridge dead time reset value, least interlock time rounded up
`define GDF_TD_NS 1600
`define GDF_DT_CYC ((`GDF_TD_NS + `GDF_CLK_NS - 1) / `GDF_CLK_NS)

// soft shut-down window, longest time rounded down
`define GDF_SSD_NS 2000
`define GDF_SSD_CYC (`GDF_SSD_NS / `GDF_CLK_NS)

// register byte offsets
`define GDF_OFS_DEADTIME_A 5'h00
`define GDF_OFS_DEADTIME_B 5'h04
`define GDF_OFS_STATUS 5'h08
`define GDF_OFS_IRQ_STATUS 5'h0C
`define GDF_OFS_IRQ_MASK 5'h10

// status register field positions
`define GDF_ST_FAULT 0
`define GDF_ST_HALF 1
`define GDF_ST_GATE_A 2
`define GDF_ST_GATE_B 3
`define GDF_ST_SSD 4
`define GDF_ST_EXT_A 5
`define GDF_ST_EXT_B 6

// event bit positions of irq status and mask
`define GDF_EV_SET 0
`define GDF_EV_CLR 1
`define GDF_EV_MODE 2

// reset values
`define GDF_MASK_RST 3'h0
`define GDF_RDATA_RST 32'h0000_0000

`endif

// ==== src/gdf_driver.sv ====
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "gdf_cfg.svh"

// Overview of operation
// - error output pulled low while fault latched
// - fault holds until reset or long pwm idle clears fault memory
// - high reset input clears fault memory
// - pwm_in_a high requests gate A on
// - pwm_in_b high requests gate B on
// - mode select high gives half-bridge mode
// - mode select low gives direct mode
// - external error A sets fault memory
// - external error B sets fault memory
// - half-bridge inserts per-channel dead time before turn-on
// - both pwm low 60 ms clears fault
// - external fault starts soft shut-down, then holds off
// - fault state ignores pwm, keeps error asserted
module gdf_driver #(
    parameter int unsigned REACT_CYCLES = `GDF_REACT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // controller pins
    input gdf_pkg::gdf_pins_type pin_in,
    // gate outputs
    output logic gate_drive_out_a,
    output logic gate_drive_out_b,
    output logic soft_shutdown_out,
    // open-drain error output
    output logic err_n_o,
    output logic err_n_oe,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq
);
    localparam logic [23:0] REACT_LIM = 24'(REACT_CYCLES);
    localparam logic [15:0] SSD_LOAD = 16'(`GDF_SSD_CYC);
    localparam gdf_pkg::gdf_core_type CORE_RST = '{
        fsm: gdf_pkg::GDF_RUN,
        deadtime_cap_a: 16'(`GDF_DT_CYC),
        deadtime_cap_b: 16'(`GDF_DT_CYC),
        mask: `GDF_MASK_RST,
        waitreq: 1'b1,
        rdata: `GDF_RDATA_RST,
        default: '0
    };

    gdf_pkg::gdf_pins_type s;
    gdf_pkg::gdf_core_type q;
    gdf_pkg::gdf_core_type d;
    logic ext;
    logic faulted;
    logic run;
    logic req_a;
    logic req_b;
    logic clr_req;
    logic bus_req;
    logic acc_wr;
    logic [31:0] status;
    logic [2:0] new_ev;
    logic [2:0] w1c;

    gdf_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(pin_in),
        .pin_sync(s)
    );

    // byte-lane merge for the 16-bit dead time registers
    function automatic logic [15:0] gdf_merge16(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0])
        begin
            r[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            r[15:8] = wdata[15:8];
        end
        return r;
    endfunction : gdf_merge16

    assign ext = s.ext_err_a | s.ext_err_b;
    assign faulted = q.fsm != gdf_pkg::GDF_RUN;
    // pwm ignored in fault and in the cycle a fault arrives
    assign run = !faulted && !ext;
    assign req_a = s.pwm_in_a && run;
    assign req_b = s.pwm_in_b && run;
    // reset pin or long pwm idle; an active external error wins
    assign clr_req = (s.fault_reset || q.react == REACT_LIM) && !ext;
    assign bus_req = avs_read || avs_write;
    assign acc_wr = avs_write && !q.waitreq;

    always_comb
    begin
        status = '0;
        status[`GDF_ST_FAULT] = faulted;
        status[`GDF_ST_HALF] = s.mode_sel;
        status[`GDF_ST_GATE_A] = q.gate_a;
        status[`GDF_ST_GATE_B] = q.gate_b;
        status[`GDF_ST_SSD] = q.ssd_out;
        status[`GDF_ST_EXT_A] = s.ext_err_a;
        status[`GDF_ST_EXT_B] = s.ext_err_b;
    end

    always_comb
    begin
        d = q;
        new_ev = '0;
        w1c = '0;

        // idle counter saturates so a long idle keeps clearing
        if (s.pwm_in_a || s.pwm_in_b)
        begin
            d.react = '0;
        end
        else if (q.react != REACT_LIM)
        begin
            d.react = q.react + 24'h00_0001;
        end

        case (q.fsm)
            gdf_pkg::GDF_RUN:
            begin
                if (ext)
                begin
                    d.fsm = gdf_pkg::GDF_SSD;
                    d.ssd = SSD_LOAD;
                    new_ev[`GDF_EV_SET] = 1'b1;
                end
            end
            gdf_pkg::GDF_SSD:
            begin
                d.ssd = q.ssd - 16'h0001;
                if (clr_req)
                begin
                    d.fsm = gdf_pkg::GDF_RUN;
                    d.ssd = '0;
                    new_ev[`GDF_EV_CLR] = 1'b1;
                end
                else if (q.ssd <= 16'h0001)
                begin
                    d.fsm = gdf_pkg::GDF_HOLD;
                end
            end
            gdf_pkg::GDF_HOLD:
            begin
                if (clr_req)
                begin
                    d.fsm = gdf_pkg::GDF_RUN;
                    new_ev[`GDF_EV_CLR] = 1'b1;
                end
            end
            default:
            begin
                d.fsm = gdf_pkg::GDF_HOLD;
            end
        endcase
        d.ssd_out = d.fsm == gdf_pkg::GDF_SSD;
        d.err_oe = d.fsm != gdf_pkg::GDF_RUN;

        if (s.mode_sel)
        begin
            // half-bridge: count only while the other side is off and idle
            if (req_a && !req_b && !q.gate_b)
            begin
                d.cnt_a = (q.cnt_a == 16'hFFFF) ? q.cnt_a : q.cnt_a + 16'h0001;
            end
            else
            begin
                d.cnt_a = '0;
            end
            if (req_b && !req_a && !q.gate_a)
            begin
                d.cnt_b = (q.cnt_b == 16'hFFFF) ? q.cnt_b : q.cnt_b + 16'h0001;
            end
            else
            begin
                d.cnt_b = '0;
            end
            d.gate_a = req_a && !req_b && !q.gate_b && q.cnt_a >= q.deadtime_cap_a;
            d.gate_b = req_b && !req_a && !q.gate_a && q.cnt_b >= q.deadtime_cap_b;
        end
        else
        begin
            d.cnt_a = '0;
            d.cnt_b = '0;
            d.gate_a = req_a;
            d.gate_b = req_b;
        end

        d.mode_prev = s.mode_sel;
        new_ev[`GDF_EV_MODE] = s.mode_sel != q.mode_prev;

        // bus: waitrequest drops for one cycle after a request is seen
        d.waitreq = !(bus_req && q.waitreq);
        if (avs_read && q.waitreq)
        begin
            case (avs_address)
                `GDF_OFS_DEADTIME_A: d.rdata = {16'h0000, q.deadtime_cap_a};
                `GDF_OFS_DEADTIME_B: d.rdata = {16'h0000, q.deadtime_cap_b};
                `GDF_OFS_STATUS: d.rdata = status;
                `GDF_OFS_IRQ_STATUS: d.rdata = {29'h0000_0000, q.ev};
                `GDF_OFS_IRQ_MASK: d.rdata = {29'h0000_0000, q.mask};
                default: d.rdata = '0;
            endcase
        end
        if (acc_wr)
        begin
            case (avs_address)
                `GDF_OFS_DEADTIME_A:
                begin
                    d.deadtime_cap_a = gdf_merge16(q.deadtime_cap_a, avs_writedata,
                        avs_byteenable);
                end
                `GDF_OFS_DEADTIME_B:
                begin
                    d.deadtime_cap_b = gdf_merge16(q.deadtime_cap_b, avs_writedata,
                        avs_byteenable);
                end
                `GDF_OFS_IRQ_STATUS:
                begin
                    w1c = avs_byteenable[0] ? avs_writedata[2:0] : 3'h0;
                end
                `GDF_OFS_IRQ_MASK:
                begin
                    if (avs_byteenable[0])
                    begin
                        d.mask = avs_writedata[2:0];
                    end
                end
                default:
                begin
                    d.mask = q.mask;
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        d.ev = (q.ev & ~w1c) | new_ev;
        d.irq = |(d.ev & d.mask);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= CORE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign gate_drive_out_a = q.gate_a;
    assign gate_drive_out_b = q.gate_b;
    assign soft_shutdown_out = q.ssd_out;
    // open drain: the pin value is a constant low, not a flop, only enable moves
    assign err_n_o = 1'b0;
    assign err_n_oe = q.err_oe;
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign irq = q.irq;

    default clocking gdf_cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence fault_entry_s;
        !faulted ##0 ext;
    endsequence

    sequence soft_off_s;
        soft_shutdown_out && !gate_drive_out_a && !gate_drive_out_b;
    endsequence

    err_low_a: assert property (faulted |-> err_n_oe)
        else $error("error output released while fault latched");
    fault_hold_a: assert property (faulted && !clr_req |=> faulted)
        else $error("fault left without a reset");
    reset_clear_a: assert property (faulted && s.fault_reset && !ext |=> !faulted)
        else $error("reset input did not clear fault");
    direct_a_a: assert property (!s.mode_sel && run && s.pwm_in_a |=> gate_drive_out_a)
        else $error("gate A not driven for request");
    direct_b_a: assert property (!s.mode_sel && run && s.pwm_in_b |=> gate_drive_out_b)
        else $error("gate B not driven for request");
    hb_exclusive_a: assert property ($past(s.mode_sel) |-> !(gate_drive_out_a && gate_drive_out_b))
        else $error("both gates on in half-bridge mode");
    direct_both_a: assert property (!s.mode_sel && run && s.pwm_in_a && s.pwm_in_b
        |=> gate_drive_out_a && gate_drive_out_b)
        else $error("direct mode did not drive both gates");
    ext_a_set_a: assert property (s.ext_err_a |=> faulted && err_n_oe)
        else $error("external error A did not set fault");
    ext_b_set_a: assert property (s.ext_err_b |=> faulted && err_n_oe)
        else $error("external error B did not set fault");
    deadtime_a_a: assert property ($rose(gate_drive_out_a) && $past(s.mode_sel)
        |-> $past(q.cnt_a) >= $past(q.deadtime_cap_a) && $past(!gate_drive_out_b))
        else $error("gate A turned on before its dead time");
    idle_clear_a: assert property (faulted && q.react == REACT_LIM && !ext |=> !faulted)
        else $error("long pwm idle did not clear fault");
    // a clear may abort the window one cycle in, so the second cycle accepts that too
    soft_stop_a: assert property (fault_entry_s |=> soft_off_s ##1
        ((!faulted || soft_shutdown_out) && !gate_drive_out_a && !gate_drive_out_b))
        else $error("soft shut-down not started on external fault");
    fault_gates_a: assert property (faulted |=> !gate_drive_out_a && !gate_drive_out_b)
        else $error("gate switched while in fault state");
    sync_delay_a: assert property (s == $past(pin_in, 2))
        else $error("pin synchroniser delay is not two cycles");
    bus_answer_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

endmodule : gdf_driver

// ==== src/gdf_pkg.sv ====
package gdf_pkg;

    // controller-side pins of the driver
    typedef struct packed {
        logic pwm_in_a;
        logic pwm_in_b;
        logic mode_sel;
        logic fault_reset;
        logic ext_err_a;
        logic ext_err_b;
    } gdf_pins_type;

    typedef struct packed {
        gdf_pins_type meta;
        gdf_pins_type sync;
    } gdf_sync_type;

    typedef enum logic [1:0] {
        GDF_RUN,
        GDF_SSD,
        GDF_HOLD
    } gdf_fsm_type;

    typedef struct packed {
        gdf_fsm_type fsm;
        logic [15:0] deadtime_cap_a;
        logic [15:0] deadtime_cap_b;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [23:0] react;
        logic [15:0] ssd;
        logic gate_a;
        logic gate_b;
        logic err_oe;
        logic ssd_out;
        logic mode_prev;
        logic [2:0] ev;
        logic [2:0] mask;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } gdf_core_type;

endpackage : gdf_pkg

// ==== src/gdf_sync.sv ====
`timescale 1ns/1ns
module gdf_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // raw pins and their synchronised copy
    input gdf_pkg::gdf_pins_type pin_in,
    output gdf_pkg::gdf_pins_type pin_sync
);
    gdf_pkg::gdf_sync_type s_q;
    gdf_pkg::gdf_sync_type s_d;

    // first stage feeds only the second one
    always_comb
    begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q.sync;

endmodule : gdf_sync

// ==== testbench/gdf_ctrl_model.sv ====
`timescale 1ns/1ns
module gdf_ctrl_model (
    // clock
    input wire logic sys_clk,
    // switching requests from the bench
    input wire logic [1:0] req,
    input wire logic obey,
    input wire logic half,
    // driver side
    input wire logic gate_a,
    input wire logic gate_b,
    input wire logic err_n_oe,
    output logic fault_n,
    output logic [1:0] pwm,
    output int shoot_cnt
);
    // external pull-up on the open-drain fault line
    assign fault_n = err_n_oe ? 1'b0 : 1'b1;
    // a well-behaved controller stops switching while the fault line is low;
    // obey low lets a scenario keep switching to prove the driver ignores it
    assign pwm = (obey && !fault_n) ? 2'b00 : req;
    // mode reaches the gates three edges after the pin, so judge against that copy
    logic [2:0] half_q = 3'h0;
    int shoot_q = 0;
    assign shoot_cnt = shoot_q;
    // the power stage would short the rail if both gates conducted together
    always @(posedge sys_clk)
    begin
        if (half_q[2] && gate_a && gate_b)
            shoot_q <= shoot_q + 1;
        half_q <= {half_q[1:0], half};
    end
endmodule : gdf_ctrl_model

// ==== testbench/tb_dual_gate_driver_fault_logic.sv ====
`timescale 1ns/1ns
module tb_dual_gate_driver_fault_logic;
    logic sys_clk;
    logic nrst;
    logic [1:0] req;
    logic [1:0] prev;
    logic obey;
    logic mode_sel;
    logic fault_reset;
    logic [1:0] ext_err;
    logic [1:0] pwm;
    logic fault_n;
    int shoot_cnt;
    logic gate_a;
    logic gate_b;
    logic ssd;
    logic err_o;
    logic err_oe;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [31:0] exp_q[$];
    int fail_count;
    int n_compared;
    int seed;
    int gap;

    // short idle-clear count keeps the run brief
    gdf_driver #(.REACT_CYCLES(50)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst),
        .pin_in({pwm, mode_sel, fault_reset, ext_err}),
        .gate_drive_out_a(gate_a), .gate_drive_out_b(gate_b),
        .soft_shutdown_out(ssd), .err_n_o(err_o), .err_n_oe(err_oe),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq)
    );

    gdf_ctrl_model u_ctrl (
        .sys_clk(sys_clk), .req(req), .obey(obey), .half(mode_sel),
        .gate_a(gate_a), .gate_b(gate_b), .err_n_oe(err_oe),
        .fault_n(fault_n), .pwm(pwm), .shoot_cnt(shoot_cnt)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // outputs are compared mid-cycle, where registered values have settled
    task automatic see(input logic [6:0] exp);
        @(negedge sys_clk);
        chk({gate_a, gate_b, ssd, err_oe, err_o, irq, fault_n}, exp);
        @(posedge sys_clk);
    endtask : see

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic done;
        int n;
        done = 1'b0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // the request stands until the edge at which waitrequest is seen low
        for (n = 0; n < 20 && !done; n++)
        begin
            @(posedge sys_clk);
            done = (avs_waitrequest === 1'b0);
        end
        if (!done)
        begin
            fail_count++;
            end_sim();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    // read data are judged by the watcher as soon as the slave answers
    always @(posedge sys_clk)
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk(avs_readdata, exp_q.pop_front());

    initial
    begin
        cyc(20000);
        fail_count++;
        end_sim();
    end

    initial
    begin
        seed = 32'h79e0_293b;
        nrst = 1'b0;
        req = 2'b00;
        obey = 1'b1;
        mode_sel = 1'b0;
        fault_reset = 1'b0;
        ext_err = 2'b00;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        fail_count = 0;
        n_compared = 0;
        cyc(6);
        nrst <= 1'b1;
        see(7'h01);
        rd(5'h00, 32'h0000_00c8);
        rd(5'h04, 32'h0000_00c8);
        rd(5'h08, 32'h0000_0000);
        rd(5'h14, 32'h0000_0000);
        rd(5'h10, 32'h0000_0000);
        // direct mode with random requests; the pins reach the gates on the third edge
        repeat (10)
        begin
            prev = req;
            req <= 2'($random(seed));
            cyc(1);
            see({prev, 5'h01});
            cyc(2);
            see({req, 5'h01});
        end
        // half-bridge: a short dead time shows the exact gap between channels
        bus(1'b1, 5'h00, 32'h0000_0003);
        bus(1'b1, 5'h04, 32'h0000_0003);
        rd(5'h04, 32'h0000_0003);
        mode_sel <= 1'b1;
        req <= 2'b10;
        cyc(20);
        see(7'h41);
        rd(5'h08, 32'h0000_0006);
        req <= 2'b01;
        for (gap = 0; gap < 30 && gate_a !== 1'b0; gap++)
            @(negedge sys_clk);
        for (gap = 0; gap < 30 && gate_b !== 1'b1; gap++)
            @(negedge sys_clk);
        chk(gap, 4);
        cyc(1);
        req <= 2'b11;
        cyc(6);
        see(7'h01);
        // external fault A while the controller keeps switching
        bus(1'b1, 5'h10, 32'h0000_0001);
        mode_sel <= 1'b0;
        obey <= 1'b0;
        cyc(6);
        ext_err <= 2'b10;
        cyc(2);
        ext_err <= 2'b00;
        cyc(4);
        see(7'h1a);
        cyc(300);
        see(7'h0a);
        rd(5'h08, 32'h0000_0001);
        fault_reset <= 1'b1;
        cyc(2);
        fault_reset <= 1'b0;
        cyc(4);
        see(7'h63);
        rd(5'h0c, 32'h0000_0007);
        bus(1'b1, 5'h0c, 32'h0000_0007);
        rd(5'h0c, 32'h0000_0000);
        see(7'h61);
        // external fault B cleared by the controller idling both inputs
        obey <= 1'b1;
        ext_err <= 2'b01;
        cyc(2);
        ext_err <= 2'b00;
        cyc(20);
        see(7'h1a);
        cyc(100);
        see(7'h63);
        chk(shoot_cnt, 0);
        chk(exp_q.size(), 0);
        end_sim();
    end
endmodule : tb_dual_gate_driver_fault_logic
